// >>> rtl/host_bus_strap_pkg.sv
// Constants, field layouts and register map of the host bus strap loader
package host_bus_strap_pkg;

  // ****************************************************************
  // Strap field layout
  // ****************************************************************
  localparam int STRAP_COUNT = 7;
  localparam int BUS_TYPE_LSB = 0;
  localparam int BUS_TYPE_MSB = 2;
  localparam int RSVD_STRAP_BIT = 3;
  localparam int ENDIAN_BIT = 4;
  localparam int WAIT_POL_BIT = 5;
  localparam int CLK_DIV_BIT = 6;

  // Host bus codes: endian strap on top, bus type straps below
  localparam logic [3:0] CODE_A_BIG = 4'h8;
  localparam logic [3:0] CODE_A_LITTLE = 4'h0;
  localparam logic [3:0] CODE_B_BIG = 4'h9;
  localparam logic [3:0] CODE_C_BIG = 4'hA;
  localparam logic [3:0] CODE_GEN1_BIG = 4'hB;
  localparam logic [3:0] CODE_GEN1_LITTLE = 4'h3;
  localparam logic [3:0] CODE_GEN2_LITTLE = 4'h4;
  localparam logic [3:0] CODE_F_BIG = 4'hD;
  localparam logic [3:0] CODE_G_BIG = 4'hE;

  typedef enum logic [2:0] {
    PROTO_A,
    PROTO_B,
    PROTO_C,
    PROTO_GEN1,
    PROTO_GEN2,
    PROTO_F,
    PROTO_G,
    PROTO_RSVD
  } bus_proto_t;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;

  // ****************************************************************
  // APB register map
  // ****************************************************************
  localparam int APB_AW = 8;
  localparam logic [7:0] ADDR_STRAP_STATUS = 8'h00;
  localparam logic [7:0] ADDR_WAIT_CTRL = 8'h04;
  localparam logic [7:0] ADDR_HOST_STATUS = 8'h08;

  // Strap status fields
  localparam int STS_STRAPS_LSB = 0;
  localparam int STS_PROTO_LSB = 8;
  localparam int STS_BIG_ENDIAN_BIT = 11;
  localparam int STS_RSVD_CFG_BIT = 12;
  localparam int STS_VALID_BIT = 13;
  localparam int STS_CLK_DIV_BIT = 14;
  localparam int STS_WAIT_POL_BIT = 15;

  // Wait control fields
  localparam int WCTL_STRETCH_LSB = 0;
  localparam int WCTL_ENABLE_BIT = 8;
  localparam logic [7:0] WAIT_STRETCH_RST = 8'h04;
  localparam logic WAIT_ENABLE_RST = 1'b1;

  // Host status fields
  localparam int HST_ADDR0_BIT = 0;
  localparam int HST_WAIT_ACT_BIT = 1;
  localparam int HST_WAIT_CNT_LSB = 8;

endpackage

// >>> rtl/strap_sync.sv
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/100ps

module strap_sync #(
  parameter int SYNC_W = 1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [SYNC_W-1:0] async_in,
  output logic [SYNC_W-1:0] sync_out
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (SYNC_W < 1) begin : g_bad_width
    $error("strap_sync needs a width of at least one");
  end

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  // First stage feeds only the second stage
  always_comb begin
    d = q;
    d.meta = async_in;
    d.stable = q.meta;
  end

  // Reset loads constants only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stable;

endmodule // strap_sync

// >>> rtl/host_bus_strap_config.sv
// Power-on strap capture, host bus decode, wait output and APB view
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps

module host_bus_strap_config #(
  parameter int STRAP_W = 7
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Board strap and host pins
  input wire logic [STRAP_W-1:0] strap_inputs,
  input wire logic low_address_bit,
  input wire logic host_cycle_start,
  // APB slave for the status and wait control words
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Captured configuration, frozen until the next reset; addr0_effective follows the host pin except for protocols A, GEN1, F and G, where it stays low
  output host_bus_strap_pkg::bus_proto_t bus_proto,
  output logic big_endian,
  output logic addr0_effective,
  output logic addr0_is_data_strobe,
  output logic size_encoded_strobes,
  output logic config_valid,
  output logic reserved_config,
  // Bus clock enable and the wait pin
  output logic bus_clk_en,
  output logic wait_out,
  output logic wait_oe
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (STRAP_W != host_bus_strap_pkg::STRAP_COUNT) begin : g_bad_straps
    $error("host_bus_strap_config serves exactly seven straps");
  end

  // Loading before both synchroniser stages are full would latch reset zeros
  if (host_bus_strap_pkg::SETTLE_CYCLES < 2'h2) begin : g_bad_settle
    $error("host_bus_strap_config needs a settle count of at least two");
  end

  // The strap copy must fit below the protocol field of the status word
  if (host_bus_strap_pkg::STS_STRAPS_LSB + STRAP_W >
      host_bus_strap_pkg::STS_PROTO_LSB) begin : g_bad_status_map
    $error("host_bus_strap_config status fields overlap");
  end

  // The remaining extension count must fit inside one data word
  if (host_bus_strap_pkg::HST_WAIT_CNT_LSB + 8 > 32) begin : g_bad_host_map
    $error("host_bus_strap_config host status field too high");
  end

  typedef enum logic [1:0] {
    CAP_SETTLE,
    CAP_LOAD,
    CAP_RUN
  } cap_state_t;

  typedef struct packed {
    // Capture sequence
    cap_state_t st;
    logic [1:0] settle;
    // Captured straps and what they decode to
    logic [STRAP_W-1:0] straps;
    host_bus_strap_pkg::bus_proto_t proto;
    logic big_endian;
    logic rsvd_cfg;
    logic valid;
    logic addr0_eff;
    logic addr0_lds;
    logic size_strobes;
    // Bus clock divider
    logic div_phase;
    logic bus_clk_en;
    // Wait extension
    logic wait_en;
    logic [7:0] stretch;
    logic [7:0] wait_cnt;
    logic wait_act;
    logic wait_out;
    logic wait_oe;
    // APB answer, one cycle
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  // Protocol reads reserved until the straps are in, so nothing acts on a half-known bus
  localparam state_t STATE_RST = '{
    st: CAP_SETTLE,
    proto: host_bus_strap_pkg::PROTO_RSVD,
    wait_en: host_bus_strap_pkg::WAIT_ENABLE_RST,
    stretch: host_bus_strap_pkg::WAIT_STRETCH_RST,
    default: '0
  };

  state_t q;
  state_t d;
  logic [STRAP_W-1:0] straps_sync;
  logic addr0_sync;
  logic apb_access;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************

  // Map a four-bit host bus code onto a protocol
  function automatic host_bus_strap_pkg::bus_proto_t decode_proto(input logic [3:0] code);
    host_bus_strap_pkg::bus_proto_t p;
    p = host_bus_strap_pkg::PROTO_RSVD;
    case (code)
      host_bus_strap_pkg::CODE_A_BIG: p = host_bus_strap_pkg::PROTO_A;
      host_bus_strap_pkg::CODE_A_LITTLE: p = host_bus_strap_pkg::PROTO_A;
      host_bus_strap_pkg::CODE_B_BIG: p = host_bus_strap_pkg::PROTO_B;
      host_bus_strap_pkg::CODE_C_BIG: p = host_bus_strap_pkg::PROTO_C;
      host_bus_strap_pkg::CODE_GEN1_BIG: p = host_bus_strap_pkg::PROTO_GEN1;
      host_bus_strap_pkg::CODE_GEN1_LITTLE: p = host_bus_strap_pkg::PROTO_GEN1;
      host_bus_strap_pkg::CODE_GEN2_LITTLE: p = host_bus_strap_pkg::PROTO_GEN2;
      host_bus_strap_pkg::CODE_F_BIG: p = host_bus_strap_pkg::PROTO_F;
      host_bus_strap_pkg::CODE_G_BIG: p = host_bus_strap_pkg::PROTO_G;
      default: p = host_bus_strap_pkg::PROTO_RSVD;
    endcase
    return p;
  endfunction

  // Protocols whose address bit zero carries no meaning inside
  function automatic logic ignores_addr0(input host_bus_strap_pkg::bus_proto_t p);
    logic r;
    r = 1'b0;
    case (p)
      host_bus_strap_pkg::PROTO_A: r = 1'b1;
      host_bus_strap_pkg::PROTO_GEN1: r = 1'b1;
      host_bus_strap_pkg::PROTO_F: r = 1'b1;
      host_bus_strap_pkg::PROTO_G: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  // Straps are board wiring, still resynchronised since they are pins
  strap_sync #(
    .SYNC_W(STRAP_W)
  ) u_strap_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(strap_inputs),
    .sync_out(straps_sync)
  );

  // Host address bit zero arrives from outside this clock domain
  strap_sync #(
    .SYNC_W(1)
  ) u_addr0_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(low_address_bit),
    .sync_out(addr0_sync)
  );

  assign apb_access = psel && penable;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    d = q;
    d.pready = 1'b0;
    d.pslverr = 1'b0;

    // Capture sequence: wait for the synchroniser to fill, load once
    case (q.st)
      CAP_SETTLE: begin
        if (q.settle == host_bus_strap_pkg::SETTLE_CYCLES - 2'h1) begin
          d.st = CAP_LOAD;
        end else begin
          d.settle = q.settle + 2'h1;
        end
      end
      CAP_LOAD: begin
        // Load from the synchronised copy: a pin that slews near release
        // cannot then split the code between two sampled values
        d.straps = straps_sync;
        d.proto = decode_proto({straps_sync[host_bus_strap_pkg::ENDIAN_BIT],
          straps_sync[host_bus_strap_pkg::BUS_TYPE_MSB:host_bus_strap_pkg::BUS_TYPE_LSB]});
        d.big_endian = straps_sync[host_bus_strap_pkg::ENDIAN_BIT];
        // Reserved strap low or unknown code flags a broken board
        d.rsvd_cfg = (d.proto == host_bus_strap_pkg::PROTO_RSVD)
          || !straps_sync[host_bus_strap_pkg::RSVD_STRAP_BIT];
        d.addr0_lds = (d.proto == host_bus_strap_pkg::PROTO_B);
        d.size_strobes = (d.proto == host_bus_strap_pkg::PROTO_C);
        d.valid = 1'b1;
        d.st = CAP_RUN;
      end
      CAP_RUN: begin
        // Captured configuration stays frozen until the next reset
        d.st = CAP_RUN;
      end
      default: begin
        d.st = CAP_SETTLE;
      end
    endcase

    // Bus clock enable: every cycle, or every other one when divided
    // An enable pulse instead of a divided clock keeps one clock tree;
    // every consumer must qualify its updates with it
    if (q.valid && q.straps[host_bus_strap_pkg::CLK_DIV_BIT]) begin
      d.bus_clk_en = q.div_phase;
      d.div_phase = !q.div_phase;
    end else begin
      d.bus_clk_en = q.valid;
      d.div_phase = 1'b0;
    end

    // Address bit zero masked where the bus leaves it unused
    if (q.valid && !ignores_addr0(q.proto)) begin
      d.addr0_eff = addr0_sync;
    end else begin
      d.addr0_eff = 1'b0;
    end

    // Cycle extension counted in bus clock ticks, so the divide applies
    // A start pulse during an extension is dropped, not queued
    if (q.wait_act) begin
      if (q.bus_clk_en) begin
        if (q.wait_cnt == 8'h01) begin
          d.wait_act = 1'b0;
          d.wait_cnt = 8'h00;
        end else begin
          d.wait_cnt = q.wait_cnt - 8'h01;
        end
      end
    end else if (q.valid && q.wait_en && host_cycle_start && (q.stretch != 8'h00)) begin
      d.wait_act = 1'b1;
      d.wait_cnt = q.stretch;
    end

    // Drive the pin only while extending; the pull resistor idles it
    d.wait_oe = d.wait_act;
    if (d.wait_act) begin
      d.wait_out = q.straps[host_bus_strap_pkg::WAIT_POL_BIT];
    end else begin
      d.wait_out = !q.straps[host_bus_strap_pkg::WAIT_POL_BIT];
    end

    // APB: one wait state, read data and error land with pready
    // Only three words decode; any other word answers with an error and zero data
    if (apb_access && !q.pready) begin
      d.pready = 1'b1;
      d.prdata = 32'h0000_0000;
      case (paddr)
        host_bus_strap_pkg::ADDR_STRAP_STATUS: begin
          d.prdata[host_bus_strap_pkg::STS_STRAPS_LSB +: STRAP_W] = q.straps;
          d.prdata[host_bus_strap_pkg::STS_PROTO_LSB +: 3] = q.proto;
          d.prdata[host_bus_strap_pkg::STS_BIG_ENDIAN_BIT] = q.big_endian;
          d.prdata[host_bus_strap_pkg::STS_RSVD_CFG_BIT] = q.rsvd_cfg;
          d.prdata[host_bus_strap_pkg::STS_VALID_BIT] = q.valid;
          d.prdata[host_bus_strap_pkg::STS_CLK_DIV_BIT] =
            q.straps[host_bus_strap_pkg::CLK_DIV_BIT];
          d.prdata[host_bus_strap_pkg::STS_WAIT_POL_BIT] =
            q.straps[host_bus_strap_pkg::WAIT_POL_BIT];
        end
        host_bus_strap_pkg::ADDR_WAIT_CTRL: begin
          d.prdata[host_bus_strap_pkg::WCTL_STRETCH_LSB +: 8] = q.stretch;
          d.prdata[host_bus_strap_pkg::WCTL_ENABLE_BIT] = q.wait_en;
        end
        host_bus_strap_pkg::ADDR_HOST_STATUS: begin
          d.prdata[host_bus_strap_pkg::HST_ADDR0_BIT] = q.addr0_eff;
          d.prdata[host_bus_strap_pkg::HST_WAIT_ACT_BIT] = q.wait_act;
          d.prdata[host_bus_strap_pkg::HST_WAIT_CNT_LSB +: 8] = q.wait_cnt;
        end
        default: begin
          d.pslverr = 1'b1; // Unmapped word answers with an error
        end
      endcase
    end

    // Writes take effect on the completing edge; status words ignore them
    // A write to a status word is accepted silently so drivers may write back
    if (apb_access && q.pready && pwrite && (paddr == host_bus_strap_pkg::ADDR_WAIT_CTRL)) begin
      if (pstrb[0]) begin
        d.stretch = pwdata[host_bus_strap_pkg::WCTL_STRETCH_LSB +: 8];
      end
      if (pstrb[1]) begin
        d.wait_en = pwdata[host_bus_strap_pkg::WCTL_ENABLE_BIT];
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Synchronous reset restores constants; straps reload after release
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register
  // ****************************************************************
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign bus_proto = q.proto;
  assign big_endian = q.big_endian;
  assign addr0_effective = q.addr0_eff;
  assign addr0_is_data_strobe = q.addr0_lds;
  assign size_encoded_strobes = q.size_strobes;
  assign config_valid = q.valid;
  assign reserved_config = q.rsvd_cfg;
  assign bus_clk_en = q.bus_clk_en;
  assign wait_out = q.wait_out;
  assign wait_oe = q.wait_oe;

endmodule // host_bus_strap_config

// >>> sim/host_bus_strap_properties.sv
// Concurrent checks on the ports of the host bus strap loader
`timescale 1ns/100ps

module host_bus_strap_properties #(
  parameter int STRAP_W = 7
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [STRAP_W-1:0] strap_inputs,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input host_bus_strap_pkg::bus_proto_t bus_proto,
  input wire logic big_endian,
  input wire logic addr0_effective,
  input wire logic addr0_is_data_strobe,
  input wire logic size_encoded_strobes,
  input wire logic config_valid,
  input wire logic bus_clk_en,
  input wire logic wait_out,
  input wire logic wait_oe
);
  // ****************************************************************
  // Reference copy of the straps
  // ****************************************************************
  // Expected protocol per {endian, type} code; 7 marks reserved codes
  localparam logic [2:0] PMAP [16] = '{3'h0, 3'h7, 3'h7, 3'h3, 3'h4, 3'h7, 3'h7, 3'h7,
    3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5, 3'h6, 3'h7};
  logic [1:0] cnt_q;
  logic [STRAP_W-1:0] cap_q;
  logic [3:0] code;

  // Grab the pins at the first edge after release; straps hold still then
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_q <= 2'h0;
    end else if (cnt_q != 2'h3) begin
      cnt_q <= cnt_q + 2'h1;
    end
    if (!sys_rst && cnt_q == 2'h0) begin
      cap_q <= strap_inputs;
    end
  end
  assign code = {cap_q[4], cap_q[2:0]};

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  valid_hold_a:
    assert property (config_valid |=> config_valid) else $error("config valid dropped");
  cfg_stable_a:
    assert property (config_valid && $past(config_valid) |-> $stable(bus_proto)
      && $stable(big_endian)) else $error("config changed after capture");
  proto_decode_a:
    assert property (config_valid |-> bus_proto == PMAP[code]) else $error("bad protocol");
  endian_cap_a:
    assert property (config_valid |-> big_endian == cap_q[4]) else $error("bad endian");
  strobe_flags_a:
    assert property (config_valid |-> addr0_is_data_strobe == (code == 4'h9)
      && size_encoded_strobes == (code == 4'hA)) else $error("bad strobe flags");
  wait_level_a:
    assert property (config_valid && $past(config_valid) |-> wait_out == (wait_oe ~^ cap_q[5]))
      else $error("bad wait level");
  div_full_a:
    assert property (config_valid && $past(config_valid) && !cap_q[6] |-> bus_clk_en)
      else $error("bus clock not every cycle");
  div_half_a:
    assert property (config_valid && cap_q[6] && bus_clk_en |=> !bus_clk_en ##1 bus_clk_en)
      else $error("bus clock not halved");
  addr0_mask_a:
    assert property (bus_proto inside {host_bus_strap_pkg::PROTO_A, host_bus_strap_pkg::PROTO_GEN1,
      host_bus_strap_pkg::PROTO_F, host_bus_strap_pkg::PROTO_G} |-> !addr0_effective)
      else $error("address bit zero not ignored");
  apb_answer_a:
    assert property (psel && penable && !pready |=> pready) else $error("apb answer late");
endmodule // host_bus_strap_properties

// >>> sim/host_strap_model.sv
// Board strap wiring and host cycle source facing the loader
`timescale 1ns/100ps

module host_strap_model (
  input wire logic ref_clk,
  input wire logic [3:0] code,
  input wire logic wpol,
  input wire logic cdiv,
  input wire logic addr0,
  input wire logic start_req,
  input wire logic [31:0] host_word,
  output logic [6:0] strap_inputs,
  output logic low_address_bit,
  output logic host_cycle_start,
  output logic [15:0] host_data_pins,
  output logic bus_start_in_n
);
  logic req_q;

  // Reserved strap is wired high; endian sits above it
  assign strap_inputs = {cdiv, wpol, code[3], 1'h1, code[2:0]};
  assign low_address_bit = addr0;

  // Protocol C on a wide host takes the upper half of the host word
  assign host_data_pins = (code == 4'hA) ? host_word[31:16] : host_word[15:0];
  // Strobes that the chosen bus leaves unused idle high
  assign bus_start_in_n = 1'h1;

  // A host begins one cycle per request edge, never a held level
  always_ff @(posedge ref_clk) begin
    req_q <= start_req;
  end
  assign host_cycle_start = start_req & ~req_q;
endmodule // host_strap_model

// >>> sim/tb_host_bus_strap_config.sv
// Self-checking testbench for the host bus strap loader
`timescale 1ns/100ps

module tb_host_bus_strap_config;
  logic ref_clk, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0, code = 4'h8;
  logic wpol = 1'h0, cdiv = 1'h0, addr0 = 1'h1, start_req = 1'h0, err;
  logic [6:0] strap_inputs;
  logic low_address_bit, host_cycle_start, pready, pslverr, big_endian, addr0_effective;
  logic addr0_is_data_strobe, size_encoded_strobes, config_valid, reserved_config;
  logic bus_clk_en, wait_out, wait_oe;
  logic [31:0] host_word = 32'h5A5A_C3C3;
  logic [15:0] host_data_pins;
  logic bus_start_in_n;
  host_bus_strap_pkg::bus_proto_t bus_proto;
  int miscompares = 0, samples_checked = 0, cycles = 0;

  host_bus_strap_config u_host_bus_strap_config (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .strap_inputs(strap_inputs),
    .low_address_bit(low_address_bit),
    .host_cycle_start(host_cycle_start),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bus_proto(bus_proto),
    .big_endian(big_endian),
    .addr0_effective(addr0_effective),
    .addr0_is_data_strobe(addr0_is_data_strobe),
    .size_encoded_strobes(size_encoded_strobes),
    .config_valid(config_valid),
    .reserved_config(reserved_config),
    .bus_clk_en(bus_clk_en),
    .wait_out(wait_out),
    .wait_oe(wait_oe)
  );
  host_strap_model u_host_strap_model (
    .ref_clk(ref_clk),
    .code(code),
    .wpol(wpol),
    .cdiv(cdiv),
    .addr0(addr0),
    .start_req(start_req),
    .host_word(host_word),
    .strap_inputs(strap_inputs),
    .low_address_bit(low_address_bit),
    .host_cycle_start(host_cycle_start),
    .host_data_pins(host_data_pins),
    .bus_start_in_n(bus_start_in_n)
  );

  // ****************************************************************
  // Clock, timeout and shared tasks
  // ****************************************************************
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // About 250 cycles are needed; the ceiling leaves ample margin
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'h1;
    // Only the bench timeout ends this wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask

  // Straps change only while reset is held, then wait for capture
  task automatic boot(input logic [3:0] c, input logic p, input logic d);
    int n;
    n = 0;
    code <= c;
    wpol <= p;
    cdiv <= d;
    sys_rst <= 1'h1;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'h0;
    while (config_valid !== 1'h1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    // The wait pin level follows the captured polarity one edge after capture
    @(posedge ref_clk);
    chk(config_valid, 1);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_codes();
    logic [3:0] c [9] = '{4'h8, 4'h0, 4'h9, 4'hA, 4'hB, 4'h3, 4'h4, 4'hD, 4'hE};
    logic [2:0] p [9] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5, 3'h6};
    int n;
    for (int i = 0; i < 9; i++) begin
      boot(c[i], i[0], i[1]);
      chk(bus_proto, p[i]);
      chk({big_endian, reserved_config}, {c[i][3], 1'h0});
      chk({addr0_is_data_strobe, size_encoded_strobes}, {p[i] == 3'h1, p[i] == 3'h2});
      chk({wait_oe, wait_out}, {1'h0, ~i[0]});
      chk({bus_start_in_n, host_data_pins},
        {1'h1, (c[i] == 4'hA) ? 16'h5A5A : 16'hC3C3});
      apb(8'h00, 1'h0, 32'h0, 4'h0);
      chk(rd[15:0], {i[0], i[1], 2'h2, c[i][3], p[i], 1'h0, i[1], i[0], c[i][3], 1'h1,
        c[i][2:0]});
      chk(addr0_effective, !(p[i] inside {3'h0, 3'h3, 3'h5, 3'h6}));
      n = 0;
      repeat (4) begin
        @(posedge ref_clk);
        n += bus_clk_en;
      end
      chk(n, i[1] ? 2 : 4);
    end
    $display("t_codes done");
  endtask

  task automatic t_hold();
    code <= 4'h4;
    wpol <= 1'h1;
    cdiv <= 1'h1;
    repeat (8) @(posedge ref_clk);
    apb(8'h00, 1'h1, 32'h0, 4'hF);
    apb(8'h00, 1'h0, 32'h0, 4'h0);
    chk(rd[6:0], 7'h1E);
    chk({bus_proto, big_endian, wait_out, bus_clk_en}, {3'h6, 3'h7});
    $display("t_hold done");
  endtask

  // Start a host cycle and count how long the wait pin is driven
  task automatic pulse(input int e);
    int n;
    n = 0;
    start_req <= 1'h1;
    @(posedge ref_clk);
    start_req <= 1'h0;
    repeat (12) begin
      @(posedge ref_clk);
      n += wait_oe;
      chk(wait_out, !wait_oe);
    end
    chk(n, e);
  endtask

  task automatic t_wait();
    apb(8'h04, 1'h0, 32'h0, 4'h0);
    chk(rd, 32'h104);
    apb(8'h0C, 1'h0, 32'h0, 4'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(8'h08, 1'h0, 32'h0, 4'h0);
    chk({err, rd[30:0]}, 32'h0);
    pulse(4);
    apb(8'h04, 1'h1, 32'h101, 4'h3);
    pulse(1);
    apb(8'h04, 1'h1, 32'h0, 4'h3);
    pulse(0);
    $display("t_wait done");
  endtask

  initial begin
    t_codes();
    t_hold();
    t_wait();
    end_of_test();
  end
endmodule // tb_host_bus_strap_config

bind host_bus_strap_config host_bus_strap_properties #(.STRAP_W(STRAP_W))
  u_host_bus_strap_properties (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .strap_inputs(strap_inputs),
    .psel(psel),
    .penable(penable),
    .pready(pready),
    .bus_proto(bus_proto),
    .big_endian(big_endian),
    .addr0_effective(addr0_effective),
    .addr0_is_data_strobe(addr0_is_data_strobe),
    .size_encoded_strobes(size_encoded_strobes),
    .config_valid(config_valid),
    .bus_clk_en(bus_clk_en),
    .wait_out(wait_out),
    .wait_oe(wait_oe)
  );
